// ==== logic/low_power_mode_control.sv ====
// Power-down sequencer: light sleep, deep sleep and stop states.
// Assumes the core gives one-cycle instruction pulses and takes its
// run/stall and service commands from this block; one clock domain.
// Interrupt requests and the hardware reset pin arrive already
// synchronised to ref_clk; the reset pin is an active high level.
// Stop mode is left only through the reset pin: irqs are ignored there.
// Deep sleep wakes through a warm-up count before the core runs again.
`timescale 1ns/1ps
module low_power_mode_control
  import lpm_pkg::*;
#(
  parameter int unsigned IRQ_N       = lpm_pkg::IRQ_SRC_N,
  parameter int unsigned WARMUP_CYCS = lpm_pkg::WARMUP_CYC
) (
  input  wire logic                          ref_clk,
  input  wire logic                          rstn,
  input  wire logic                          hw_reset,
  input  wire logic                          halt_instruction,
  input  wire logic                          stop_mode_instruction,
  input  wire logic [lpm_pkg::SYS_CTRL_W-1:0] system_control_register,
  input  wire logic                          irq_disable,
  input  wire logic [IRQ_N-1:0]              irq_pending,
  input  wire logic                          periph_on_crystal,
  output logic                               core_run,
  output logic                               osc_enable,
  output logic                               periph_clk_en,
  output logic                               hold_state,
  output logic                               wake_resume,
  output logic                               wake_service,
  output logic                               core_reset,
  output logic                               light_sleep_mode,
  output logic                               deep_sleep_mode,
  output logic                               stop_mode
);
  import lpm_pkg::*;

  pwr_state_t st_r;
  pwr_state_t st_nxt;
  logic       wake_req;
  logic       warm_start;
  logic       warm_run;
  logic       warm_done;
  logic       resume_nxt;
  logic       service_nxt;
  logic       wake_ok;
  logic       deep_sel;
  logic       in_reset_r;
  logic       in_reset_nxt;
  logic       core_run_nxt;
  logic       osc_enable_nxt;
  logic       periph_clk_en_nxt;
  logic       hold_state_nxt;
  logic       core_reset_nxt;
  logic       light_mode_nxt;
  logic       deep_mode_nxt;
  logic       stop_mode_nxt;

  // Wake request from any pending source, disable flag ignored
  assign wake_req = |irq_pending;
  assign deep_sel = system_control_register[DEEP_SEL_BIT];

  warmup_timer #(
    .W     (WARM_CNT_W),
    .COUNT (WARMUP_CYCS)
  ) u_warm (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .start   (warm_start),
    .run     (warm_run),
    .done    (warm_done)
  );

  // Next state and wake handling
  always_comb begin
    st_nxt       = st_r;
    warm_start   = 1'b0;
    warm_run     = 1'b0;
    wake_ok      = 1'b0;
    in_reset_nxt = 1'b0;
    case (st_r)
      ST_RUN: begin
        if (stop_mode_instruction) begin
          st_nxt = ST_STOP;
        end else if (halt_instruction && deep_sel) begin
          st_nxt = ST_DEEP;
        end else if (halt_instruction) begin
          st_nxt = ST_LIGHT;
        end
      end
      ST_LIGHT: begin
        if (wake_req) begin
          st_nxt  = ST_RUN;
          wake_ok = 1'b1;
        end
      end
      ST_DEEP: begin
        if (wake_req) begin
          st_nxt     = ST_WARM;
          warm_start = 1'b1;
        end
      end
      ST_WARM: begin
        warm_run = 1'b1;
        if (warm_done) begin
          st_nxt  = ST_RUN;
          wake_ok = 1'b1;
        end
      end
      ST_STOP: begin
        st_nxt = ST_STOP;
      end
      default: st_nxt = ST_RUN;
    endcase
    // Hardware reset ends every state; warm-up runs alongside it
    if (hw_reset) begin
      st_nxt       = ST_RUN;
      wake_ok      = 1'b0;
      in_reset_nxt = 1'b1;
      warm_start   = !in_reset_r;
      warm_run     = in_reset_r;
    end
  end

  // Resume or service choice at wake
  always_comb begin
    resume_nxt  = wake_ok && irq_disable;
    service_nxt = wake_ok && !irq_disable;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_r       <= ST_RUN;
      in_reset_r <= 1'b0;
    end else begin
      st_r       <= st_nxt;
      in_reset_r <= in_reset_nxt;
    end
  end

  // Output next values from the state about to be entered
  always_comb begin
    core_run_nxt      = 1'b0;
    osc_enable_nxt    = 1'b0;
    periph_clk_en_nxt = periph_on_crystal;
    hold_state_nxt    = 1'b1;
    core_reset_nxt    = hw_reset;
    light_mode_nxt    = 1'b0;
    deep_mode_nxt     = 1'b0;
    stop_mode_nxt     = 1'b0;
    case (st_nxt)
      ST_RUN: begin
        core_run_nxt      = 1'b1;
        osc_enable_nxt    = 1'b1;
        periph_clk_en_nxt = 1'b1;
        hold_state_nxt    = 1'b0;
      end
      ST_LIGHT: begin
        osc_enable_nxt    = 1'b1;
        periph_clk_en_nxt = 1'b1;
        light_mode_nxt    = 1'b1;
      end
      ST_DEEP: begin
        periph_clk_en_nxt = periph_on_crystal;
        deep_mode_nxt     = 1'b1;
      end
      ST_WARM: begin
        osc_enable_nxt    = 1'b1;
        periph_clk_en_nxt = periph_on_crystal;
        deep_mode_nxt     = 1'b1;
      end
      ST_STOP: begin
        periph_clk_en_nxt = periph_on_crystal;
        stop_mode_nxt     = 1'b1;
      end
      default: begin
        hold_state_nxt    = 1'b0;
      end
    endcase
    // Core stays stalled while the reset pin is held
    if (hw_reset) begin
      core_run_nxt = 1'b0;
    end
  end

  // Registered outputs, all straight from flops
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      core_run         <= 1'b1;
      osc_enable       <= 1'b1;
      periph_clk_en    <= 1'b1;
      hold_state       <= 1'b0;
      wake_resume      <= 1'b0;
      wake_service     <= 1'b0;
      core_reset       <= 1'b0;
      light_sleep_mode <= 1'b0;
      deep_sleep_mode  <= 1'b0;
      stop_mode        <= 1'b0;
    end else begin
      core_run         <= core_run_nxt;
      osc_enable       <= osc_enable_nxt;
      periph_clk_en    <= periph_clk_en_nxt;
      hold_state       <= hold_state_nxt;
      wake_resume      <= resume_nxt;
      wake_service     <= service_nxt;
      core_reset       <= core_reset_nxt;
      light_sleep_mode <= light_mode_nxt;
      deep_sleep_mode  <= deep_mode_nxt;
      stop_mode        <= stop_mode_nxt;
    end
  end
endmodule : low_power_mode_control

// ==== common/lpm_pkg.sv ====
// Constants and types for the low power mode controller.
// Assumes one clock domain (ref_clk, 200 MHz) and an asynchronous reset.
package lpm_pkg;
  localparam int unsigned DEEP_SEL_BIT   = 2;
  localparam int unsigned SYS_CTRL_W     = 8;
  localparam int unsigned IRQ_SRC_N      = 5;
  localparam int unsigned CLK_PERIOD_PS  = 5000;
  // Warm-up time in microseconds, and cycles derived from it (rounded up)
  localparam int unsigned WARMUP_US      = 64;
  localparam int unsigned WARMUP_CYC     =
    (WARMUP_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned WARM_CNT_W     = 16;

  typedef enum logic [2:0] {
    ST_RUN, ST_LIGHT, ST_DEEP, ST_WARM, ST_STOP
  } pwr_state_t;
endpackage : lpm_pkg

// ==== logic/warmup_timer.sv ====
// Warm-up counter for the clock source.
// Assumes start is a one-cycle pulse, as a held start keeps reloading; done is a level after the count ends.
`timescale 1ns/1ps
module warmup_timer #(
  parameter int unsigned W     = 16,
  parameter int unsigned COUNT = 12800
) (
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic start,
  input  wire logic run,
  output logic      done
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic         done_nxt;

  // Reload on start, count down while run
  always_comb begin
    cnt_nxt  = cnt_r;
    done_nxt = 1'b0;
    if (start) begin
      cnt_nxt = W'(COUNT - 1);
    end else if (run && cnt_r != '0) begin
      cnt_nxt = cnt_r - W'(1);
    end else if (run) begin
      done_nxt = 1'b1;
    end
  end

  // Register counter and done
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
      done  <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      done  <= done_nxt;
    end
  end
endmodule : warmup_timer

// ==== test/core_model.sv ====
// CPU core model: issues instruction pulses only while it is running.
// Assumes the bench raises each request for one cycle.
`timescale 1ns/1ps
module core_model (
  input  wire logic want_halt,
  input  wire logic want_stop,
  input  wire logic core_run,
  output logic      halt_instruction,
  output logic      stop_mode_instruction
);
  // A stalled core fetches nothing, so it executes nothing
  assign halt_instruction      = want_halt & core_run;
  assign stop_mode_instruction = want_stop & core_run;
endmodule : core_model

// ==== test/lpm_properties.sv ====
// Port checker for the power-down sequencer.
// Assumes the single ref_clk domain and the rstn reset.
`timescale 1ns/1ps
module lpm_properties #(parameter int unsigned IRQ_N = 5) (
  input wire logic             ref_clk,
  input wire logic             rstn,
  input wire logic             hw_reset,
  input wire logic             halt_instruction,
  input wire logic             stop_mode_instruction,
  input wire logic [7:0]       system_control_register,
  input wire logic             irq_disable,
  input wire logic [IRQ_N-1:0] irq_pending,
  input wire logic             periph_on_crystal,
  input wire logic             core_run,
  input wire logic             osc_enable,
  input wire logic             periph_clk_en,
  input wire logic             hold_state,
  input wire logic             wake_resume,
  input wire logic             wake_service,
  input wire logic             light_sleep_mode,
  input wire logic             deep_sleep_mode,
  input wire logic             stop_mode
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Halt request accepted in run state
  sequence halt_taken;
    halt_instruction && core_run && !stop_mode_instruction && !hw_reset;
  endsequence
  // Interrupt seen in light sleep
  sequence light_irq;
    light_sleep_mode && (|irq_pending) && !hw_reset;
  endsequence
  light_entry_a: assert property (halt_taken ##0 !system_control_register[2] |=> light_sleep_mode && !core_run) else $error("no light entry");
  deep_entry_a: assert property (halt_taken ##0 system_control_register[2] |=> deep_sleep_mode && !light_sleep_mode && !core_run) else $error("bad deep entry");
  deep_clocks_a: assert property (deep_sleep_mode |-> periph_clk_en == periph_on_crystal && hold_state && !core_run) else $error("deep clocks");
  stop_entry_a: assert property (stop_mode_instruction && core_run && !hw_reset |=> stop_mode && !core_run) else $error("no stop entry");
  wake_resume_a: assert property (light_irq ##0 irq_disable |=> core_run && wake_resume && !wake_service) else $error("bad resume");
  wake_service_a: assert property (light_irq ##0 !irq_disable |=> core_run && wake_service && !wake_resume) else $error("bad service");
  stop_stays_a: assert property (stop_mode && !hw_reset |=> stop_mode) else $error("stop left");
  light_clocks_a: assert property (light_sleep_mode |-> osc_enable && periph_clk_en && hold_state) else $error("light clocks");
  stop_periph_a: assert property (stop_mode |-> periph_clk_en == periph_on_crystal && hold_state) else $error("stop periph");
endmodule : lpm_properties
bind low_power_mode_control lpm_properties #(.IRQ_N(IRQ_N)) lpm_properties_inst (.*);

// ==== test/testbench.sv ====
// Self-checking bench for the power-down sequencer.
// Assumes a short warm-up parameter and the core model beside it.
`timescale 1ns/1ps
module testbench;
  import lpm_pkg::*;
  localparam int WU = 8;
  logic ref_clk = 0, rstn = 0, hw_reset = 0, irq_disable = 0;
  logic want_halt = 0, want_stop = 0, periph_on_crystal = 0;
  logic [7:0] system_control_register = 8'h00;
  logic [4:0] irq_pending = 5'h00;
  logic halt_instruction, stop_mode_instruction, core_run, osc_enable;
  logic periph_clk_en, hold_state, wake_resume, wake_service, core_reset;
  logic light_sleep_mode, deep_sleep_mode, stop_mode;
  int error_cnt = 0, comparisons = 0, cyc = 0, n;
  always #2.5 ref_clk = ~ref_clk;
  low_power_mode_control #(.WARMUP_CYCS(WU)) low_power_mode_control_inst (.*);
  core_model core_model_inst (.*);
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %0h got %0h", what, exp, got);
    end
  endtask : check
  task automatic tick(int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : tick
  // Wait for the core to run again, counting cycles
  task automatic wait_run();
    n = 0;
    do begin
      tick(1);
      n++;
    end while (core_run !== 1'b1 && n < 40);
  endtask : wait_run
  task automatic sleep(logic deep, logic dis);
    system_control_register = 8'($urandom) & 8'hfb | {5'h00, deep, 2'h0};
    irq_disable = dis;
    periph_on_crystal = 1'($urandom);
    want_halt = 1;
    tick(1);
    want_halt = 0;
    check("light", !deep, light_sleep_mode);
    check("deep", deep, deep_sleep_mode);
    check("run", 0, core_run);
    check("hold", 1, hold_state);
    if (!deep) check("osc", 1, osc_enable);
    if (!deep) check("per_light", 1, periph_clk_en);
    if (deep) check("osc_deep", 0, osc_enable);
    if (deep) check("per_deep", periph_on_crystal, periph_clk_en);
    irq_pending = 5'h01 << ($urandom % 5);
    wait_run();
    check("wake_cyc", deep ? 8'(WU + 2) : 8'h01, n[7:0]);
    check("resume", dis, wake_resume);
    check("service", !dis, wake_service);
    irq_pending = 5'h00;
    tick(2);
  endtask : sleep
  task automatic report_and_stop();
    if (error_cnt == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  // Cycle ceiling against hangs
  always @(posedge ref_clk) if (++cyc == 3000) begin
    error_cnt++;
    report_and_stop();
  end
  initial begin
    void'($urandom(20));
    repeat (6) @(posedge ref_clk);
    #1;
    check("run_rst", 1, core_run);
    rstn = 1;
    tick(1);
    for (int i = 0; i < 4; i++) sleep(i[1], i[0]);
    want_stop = 1;
    tick(1);
    want_stop = 0;
    check("stop", 1, stop_mode);
    irq_pending = 5'h1f;
    tick(20);
    check("stop_irq", 1, stop_mode);
    check("stop_per", periph_on_crystal, periph_clk_en);
    hw_reset = 1;
    tick(3);
    check("rst_core", 1, core_reset);
    check("rst_run", 0, core_run);
    hw_reset = 0;
    irq_pending = 5'h00;
    wait_run();
    check("stop_exit", 0, stop_mode);
    report_and_stop();
  end
endmodule : testbench
